/* hdl/vlan_dscp_pkg.sv */
// Constants, register indices and types shared by the VLAN/DSCP table access logic
package vlan_dscp_pkg;

   // Bus geometry
   localparam int          ADDR_W       = 16;
   localparam int          DATA_W       = 32;
   localparam int          IDX_W        = 14;
   localparam logic [1:0]  HTRANS_IDLE  = 2'h0;
   localparam logic [2:0]  HSIZE_WORD   = 3'h2;
   localparam logic [1:0]  BYTE_ALIGNED = 2'h0;

   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] VLAN_COMMAND_PENDING_IDX   = 14'h1810;
   localparam logic [IDX_W-1:0] DSCP_TABLE_COMMAND_IDX     = 14'h1811;
   localparam logic [IDX_W-1:0] DSCP_TABLE_WRITE_VALUE_IDX = 14'h1812;
   localparam logic [IDX_W-1:0] DSCP_TABLE_READ_VALUE_IDX  = 14'h1813;
   localparam logic [IDX_W-1:0] DSCP_TABLE_PENDING_IDX     = 14'h1814;
   localparam logic [IDX_W-1:0] VLAN_TABLE_COMMAND_IDX     = 14'h1830;
   localparam logic [IDX_W-1:0] VLAN_TABLE_WRITE_VALUE_IDX = 14'h1831;
   localparam logic [IDX_W-1:0] VLAN_TABLE_READ_VALUE_IDX  = 14'h1832;

   // Command word fields
   localparam int READ_NOT_WRITE_SELECT_BIT = 7;
   localparam int DSCP_INDEX_W              = 6;
   localparam int VLAN_INDEX_W              = 4;
   localparam int PENDING_BIT               = 0;

   // Table geometry
   localparam int DSCP_DEPTH   = 64;
   localparam int DSCP_PRIO_W  = 3;
   localparam int VLAN_DEPTH   = 16;
   localparam int VLAN_ENTRY_W = 16;
   localparam int VID_W        = 12;
   localparam int NUM_PORTS    = 2;

   // Entry word field positions
   localparam int MEMBER_PORT1_BIT = 15;
   localparam int UNTAG_PORT1_BIT  = 14;
   localparam int MEMBER_PORT0_BIT = 13;
   localparam int UNTAG_PORT0_BIT  = 12;
   localparam int VID_LSB          = 0;

   // Reset values
   localparam logic [DATA_W-1:0]       WORD_RESET  = 32'h0000_0000;
   localparam logic [7:0]              CMD_RESET   = 8'h00;
   localparam logic [DSCP_PRIO_W-1:0]  PRIO_RESET  = 3'h0;
   localparam logic [VLAN_ENTRY_W-1:0] ENTRY_RESET = 16'h0000;
   localparam logic [VID_W-1:0]        NULL_VID    = 12'h000;

   // Table access sequencer
   typedef enum logic [1:0] {
      ACC_IDLE,
      ACC_RUN,
      ACC_DONE
   } access_state_t;

endpackage

/* hdl/dscp_priority_mem.sv */
// DSCP priority storage: one command port and one ingress lookup port, both registered
`timescale 1ns/1ps
module dscp_priority_mem
   import vlan_dscp_pkg::*;
(
   input  wire logic                    clk_i,
   input  wire logic                    rst_n_i,
   input  wire logic                    wr_en_i,
   input  wire logic                    rd_en_i,
   input  wire logic [DSCP_INDEX_W-1:0] index_i,
   input  wire logic [DSCP_PRIO_W-1:0]  wdata_i,
   output logic      [DSCP_PRIO_W-1:0]  rdata_o,
   input  wire logic [DSCP_INDEX_W-1:0] tos_class_i,
   output logic      [DSCP_PRIO_W-1:0]  rx_priority_o
);

   logic [DSCP_PRIO_W-1:0] table_mem [DSCP_DEPTH];
   logic [DSCP_PRIO_W-1:0] rdata_next;
   logic [DSCP_PRIO_W-1:0] lookup_next;

   // Storage has no reset: contents undefined until written
   always_ff @(posedge clk_i) begin
      if (wr_en_i) begin
         table_mem[index_i] <= wdata_i; // RQ14
      end
   end

   // Read port values
   always_comb begin
      rdata_next  = rd_en_i ? table_mem[index_i] : rdata_o;
      lookup_next = table_mem[tos_class_i]; // RQ10
   end

   // Registered read data
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rdata_o       <= PRIO_RESET;
         rx_priority_o <= PRIO_RESET;
      end else begin
         rdata_o       <= rdata_next;
         rx_priority_o <= lookup_next;
      end
   end

endmodule

/* hdl/vlan_entry_store.sv */
// VLAN entry storage with command port and per-entry ingress match
`timescale 1ns/1ps
module vlan_entry_store
   import vlan_dscp_pkg::*;
(
   input  wire logic                    clk_i,
   input  wire logic                    rst_n_i,
   input  wire logic                    wr_en_i,
   input  wire logic                    rd_en_i,
   input  wire logic [VLAN_INDEX_W-1:0] index_i,
   input  wire logic [VLAN_ENTRY_W-1:0] wdata_i,
   output logic      [VLAN_ENTRY_W-1:0] rdata_o,
   input  wire logic [VID_W-1:0]        ingress_vid_i,
   input  wire logic [NUM_PORTS-1:0]    hybrid_i,
   output logic      [NUM_PORTS-1:0]    admit_o,
   output logic      [NUM_PORTS-1:0]    strip_tag_o,
   output logic                         hit_o
);

   logic [VLAN_ENTRY_W-1:0] entry_reg [VLAN_DEPTH];
   logic [VLAN_DEPTH-1:0]   match;
   logic [VLAN_DEPTH-1:0]   mem0;
   logic [VLAN_DEPTH-1:0]   mem1;
   logic [VLAN_DEPTH-1:0]   unt0;
   logic [VLAN_DEPTH-1:0]   unt1;
   logic [VLAN_ENTRY_W-1:0] rdata_next;
   logic [NUM_PORTS-1:0]    admit_next;
   logic [NUM_PORTS-1:0]    strip_next;

   // Per-entry storage and match
   for (genvar g = 0; g < VLAN_DEPTH; g++) begin : g_entry
      logic [VLAN_ENTRY_W-1:0] entry_next;
      always_comb begin
         entry_next = (wr_en_i && (index_i == VLAN_INDEX_W'(g))) ? wdata_i : entry_reg[g];
      end
      always_ff @(posedge clk_i) begin
         if (!rst_n_i) begin
            entry_reg[g] <= ENTRY_RESET; // RQ3
         end else begin
            entry_reg[g] <= entry_next;
         end
      end
      // Null VID entries never match
      assign match[g] = (entry_reg[g][VID_LSB +: VID_W] == ingress_vid_i) &&
                        (entry_reg[g][VID_LSB +: VID_W] != NULL_VID); // RQ4 RQ5
      assign mem0[g]  = match[g] & entry_reg[g][MEMBER_PORT0_BIT];
      assign mem1[g]  = match[g] & entry_reg[g][MEMBER_PORT1_BIT];
      assign unt0[g]  = match[g] & entry_reg[g][UNTAG_PORT0_BIT];
      assign unt1[g]  = match[g] & entry_reg[g][UNTAG_PORT1_BIT];
   end

   // Combined lookup result
   always_comb begin
      rdata_next = rd_en_i ? entry_reg[index_i] : rdata_o;
      admit_next = {|mem1, |mem0}; // RQ1
      strip_next = {|unt1, |unt0} & hybrid_i; // RQ2
   end

   // Registered outputs
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rdata_o     <= ENTRY_RESET;
         admit_o     <= '0;
         strip_tag_o <= '0;
         hit_o       <= 1'b0;
      end else begin
         rdata_o     <= rdata_next;
         admit_o     <= admit_next;
         strip_tag_o <= strip_next;
         hit_o       <= |match;
      end
   end

endmodule

/* hdl/vlan_dscp_table_access.sv */
// AHB-Lite register bank and sequencers for indirect VLAN and DSCP table access
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

// Contract
// RQ1: A set member bit admits matching packets and joins that port's egress domain.
// RQ2: A set untag bit strips the tag on egress when the port is hybrid.
// RQ3: Entry bits 14, 13, 12 hold port 1 untag, port 0 member, port 0 untag, reset zero.
// RQ4: Entry bits 11:0 hold the matched VLAN ID, reset zero.
// RQ5: VLAN ID zero marks a disabled entry that never matches.
// RQ6: VLAN status bit 0 is read-only pending, self-clearing when the access completes.
// RQ7: Each DSCP command write launches one access at the written type and index; a command write while pending is ignored.
// RQ8: DSCP command bit 7 selects read when one, write when zero.
// RQ9: DSCP command bits 5:0 pick one of 64 entries; bit 6, 31:8 reserved.
// RQ10: Each DSCP entry holds a three-bit receive priority for that class value.
// RQ11: Software loads the write value before the write command, then polls pending.
// RQ12: After a read, read value holds the entry once pending clears.
// RQ13: DSCP status bit 0 is read-only pending, self-clearing when the access finishes.
// RQ14: DSCP storage is not cleared by reset.
// RQ15: Software writes every DSCP entry before enabling DSCP prioritisation.
// RQ16: Software issues no command while pending; such commands are ignored.
// RQ17: Pending rises in the cycle after the command write.
module vlan_dscp_table_access
   import vlan_dscp_pkg::*;
(
   input  wire logic                   clk_i,
   input  wire logic                   rst_n_i,
   input  wire logic                   hsel_i,
   input  wire logic [ADDR_W-1:0]      haddr_i,
   input  wire logic [1:0]             htrans_i,
   input  wire logic                   hwrite_i,
   input  wire logic [2:0]             hsize_i,
   input  wire logic [DATA_W-1:0]      hwdata_i,
   input  wire logic                   hready_i,
   output logic      [DATA_W-1:0]      hrdata_o,
   output logic                        hreadyout_o,
   output logic                        hresp_o,
   input  wire logic [VID_W-1:0]       ingress_vid_i,
   input  wire logic [NUM_PORTS-1:0]   egress_port_type_config_i,
   output logic      [NUM_PORTS-1:0]   vlan_admit_o,
   output logic      [NUM_PORTS-1:0]   vlan_strip_tag_o,
   output logic                        vlan_hit_o,
   input  wire logic [DSCP_INDEX_W-1:0] tos_class_i,
   output logic      [DSCP_PRIO_W-1:0] rx_priority_o
);

   // Bus slave state
   logic [IDX_W-1:0]  addr_reg;
   logic [IDX_W-1:0]  addr_next;
   logic              wr_phase_reg;
   logic              wr_phase_next;
   logic              rd_phase_reg;
   logic              rd_phase_next;
   logic              hreadyout_next;
   logic [DATA_W-1:0] hrdata_next;
   logic              accept;
   logic              wr_en;
   logic [DATA_W-1:0] rd_word;

   // DSCP sequencer state
   access_state_t          dscp_state_reg;
   access_state_t          dscp_state_next;
   logic [7:0]             dscp_cmd_reg;
   logic [7:0]             dscp_cmd_next;
   logic [DSCP_PRIO_W-1:0] dscp_wval_reg;
   logic [DSCP_PRIO_W-1:0] dscp_wval_next;
   logic [DSCP_PRIO_W-1:0] dscp_rval_reg;
   logic [DSCP_PRIO_W-1:0] dscp_rval_next;
   logic                   dscp_mem_we;
   logic                   dscp_mem_re;
   logic [DSCP_PRIO_W-1:0] dscp_mem_rdata;
   logic                   dscp_pending;
   logic                   dscp_rnw;

   // VLAN sequencer state
   access_state_t           vlan_state_reg;
   access_state_t           vlan_state_next;
   logic [7:0]              vlan_cmd_reg;
   logic [7:0]              vlan_cmd_next;
   logic [VLAN_ENTRY_W-1:0] vlan_wval_reg;
   logic [VLAN_ENTRY_W-1:0] vlan_wval_next;
   logic [VLAN_ENTRY_W-1:0] vlan_rval_reg;
   logic [VLAN_ENTRY_W-1:0] vlan_rval_next;
   logic                    vlan_mem_we;
   logic                    vlan_mem_re;
   logic [VLAN_ENTRY_W-1:0] vlan_mem_rdata;
   logic                    vlan_pending;
   logic                    vlan_rnw;

   // Address phase qualification: word-sized, aligned, active transfers only
   always_comb begin
      accept = hsel_i && hready_i && (htrans_i != HTRANS_IDLE) && htrans_i[1] &&
               (hsize_i == HSIZE_WORD) && (haddr_i[1:0] == BYTE_ALIGNED);
      wr_en  = wr_phase_reg;
   end

   // Bus phase tracking; reads take one wait state
   always_comb begin
      addr_next      = accept ? haddr_i[ADDR_W-1:2] : addr_reg;
      wr_phase_next  = accept && hwrite_i;
      rd_phase_next  = accept && !hwrite_i;
      hreadyout_next = !(accept && !hwrite_i);
   end

   // Read multiplexer; unmapped and reserved bits read as zero
   always_comb begin
      rd_word = WORD_RESET;
      case (addr_reg)
         VLAN_COMMAND_PENDING_IDX: begin
            rd_word[PENDING_BIT] = vlan_pending; // RQ6
         end
         DSCP_TABLE_COMMAND_IDX: begin
            rd_word[READ_NOT_WRITE_SELECT_BIT]  = dscp_cmd_reg[READ_NOT_WRITE_SELECT_BIT];
            rd_word[DSCP_INDEX_W-1:0]           = dscp_cmd_reg[DSCP_INDEX_W-1:0]; // RQ9
         end
         DSCP_TABLE_WRITE_VALUE_IDX: begin
            rd_word[DSCP_PRIO_W-1:0] = dscp_wval_reg;
         end
         DSCP_TABLE_READ_VALUE_IDX: begin
            rd_word[DSCP_PRIO_W-1:0] = dscp_rval_reg; // RQ12
         end
         DSCP_TABLE_PENDING_IDX: begin
            rd_word[PENDING_BIT] = dscp_pending; // RQ13
         end
         VLAN_TABLE_COMMAND_IDX: begin
            rd_word[READ_NOT_WRITE_SELECT_BIT] = vlan_cmd_reg[READ_NOT_WRITE_SELECT_BIT];
            rd_word[VLAN_INDEX_W-1:0]          = vlan_cmd_reg[VLAN_INDEX_W-1:0];
         end
         VLAN_TABLE_WRITE_VALUE_IDX: begin
            rd_word[VLAN_ENTRY_W-1:0] = vlan_wval_reg;
         end
         VLAN_TABLE_READ_VALUE_IDX: begin
            rd_word[VLAN_ENTRY_W-1:0] = vlan_rval_reg;
         end
         default: begin
            rd_word = WORD_RESET;
         end
      endcase
   end

   // Read data captured in the wait cycle
   always_comb begin
      hrdata_next = rd_phase_reg ? rd_word : hrdata_o;
   end

   // Bus slave registers
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         addr_reg     <= '0;
         wr_phase_reg <= 1'b0;
         rd_phase_reg <= 1'b0;
         hreadyout_o  <= 1'b1;
         hrdata_o     <= WORD_RESET;
         hresp_o      <= 1'b0;
      end else begin
         addr_reg     <= addr_next;
         wr_phase_reg <= wr_phase_next;
         rd_phase_reg <= rd_phase_next;
         hreadyout_o  <= hreadyout_next;
         hrdata_o     <= hrdata_next;
         hresp_o      <= 1'b0; // Always OKAY
      end
   end

   // DSCP pending and direction
   always_comb begin
      dscp_pending = (dscp_state_reg != ACC_IDLE); // RQ13 RQ17
      dscp_rnw     = dscp_cmd_reg[READ_NOT_WRITE_SELECT_BIT]; // RQ8
      dscp_mem_we  = (dscp_state_reg == ACC_RUN) && !dscp_rnw; // RQ8
      dscp_mem_re  = (dscp_state_reg == ACC_RUN) && dscp_rnw;
   end

   // DSCP sequencer: a command write while idle starts one access
   always_comb begin
      dscp_state_next = dscp_state_reg;
      dscp_cmd_next   = dscp_cmd_reg;
      dscp_wval_next  = dscp_wval_reg;
      dscp_rval_next  = dscp_rval_reg;
      if (wr_en && (addr_reg == DSCP_TABLE_WRITE_VALUE_IDX)) begin
         dscp_wval_next = hwdata_i[DSCP_PRIO_W-1:0]; // RQ11
      end
      case (dscp_state_reg)
         ACC_IDLE: begin
            if (wr_en && (addr_reg == DSCP_TABLE_COMMAND_IDX)) begin
               dscp_cmd_next = {hwdata_i[READ_NOT_WRITE_SELECT_BIT], 1'b0,
                                hwdata_i[DSCP_INDEX_W-1:0]}; // RQ9
               dscp_state_next = ACC_RUN; // RQ7 RQ17
            end
         end
         ACC_RUN: begin
            dscp_state_next = ACC_DONE;
         end
         ACC_DONE: begin
            if (dscp_rnw) begin
               dscp_rval_next = dscp_mem_rdata; // RQ12
            end
            dscp_state_next = ACC_IDLE; // RQ13
         end
         default: begin
            dscp_state_next = ACC_IDLE;
         end
      endcase
   end

   // DSCP registers
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         dscp_state_reg <= ACC_IDLE;
         dscp_cmd_reg   <= CMD_RESET;
         dscp_wval_reg  <= PRIO_RESET;
         dscp_rval_reg  <= PRIO_RESET;
      end else begin
         dscp_state_reg <= dscp_state_next;
         dscp_cmd_reg   <= dscp_cmd_next;
         dscp_wval_reg  <= dscp_wval_next;
         dscp_rval_reg  <= dscp_rval_next;
      end
   end

   // DSCP priority table
   dscp_priority_mem u_dscp_mem (
      .clk_i         (clk_i),
      .rst_n_i       (rst_n_i),
      .wr_en_i       (dscp_mem_we),
      .rd_en_i       (dscp_mem_re),
      .index_i       (dscp_cmd_reg[DSCP_INDEX_W-1:0]),
      .wdata_i       (dscp_wval_reg),
      .rdata_o       (dscp_mem_rdata),
      .tos_class_i   (tos_class_i),
      .rx_priority_o (rx_priority_o)
   );

   // VLAN pending and direction
   always_comb begin
      vlan_pending = (vlan_state_reg != ACC_IDLE); // RQ6 RQ17
      vlan_rnw     = vlan_cmd_reg[READ_NOT_WRITE_SELECT_BIT];
      vlan_mem_we  = (vlan_state_reg == ACC_RUN) && !vlan_rnw;
      vlan_mem_re  = (vlan_state_reg == ACC_RUN) && vlan_rnw;
   end

   // VLAN sequencer: same handshake as the DSCP side
   always_comb begin
      vlan_state_next = vlan_state_reg;
      vlan_cmd_next   = vlan_cmd_reg;
      vlan_wval_next  = vlan_wval_reg;
      vlan_rval_next  = vlan_rval_reg;
      if (wr_en && (addr_reg == VLAN_TABLE_WRITE_VALUE_IDX)) begin
         vlan_wval_next = hwdata_i[VLAN_ENTRY_W-1:0]; // RQ3 RQ4
      end
      case (vlan_state_reg)
         ACC_IDLE: begin
            if (wr_en && (addr_reg == VLAN_TABLE_COMMAND_IDX)) begin
               vlan_cmd_next = {hwdata_i[READ_NOT_WRITE_SELECT_BIT], 3'h0,
                                hwdata_i[VLAN_INDEX_W-1:0]};
               vlan_state_next = ACC_RUN; // RQ17
            end
         end
         ACC_RUN: begin
            vlan_state_next = ACC_DONE;
         end
         ACC_DONE: begin
            if (vlan_rnw) begin
               vlan_rval_next = vlan_mem_rdata;
            end
            vlan_state_next = ACC_IDLE; // RQ6
         end
         default: begin
            vlan_state_next = ACC_IDLE;
         end
      endcase
   end

   // VLAN registers
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         vlan_state_reg <= ACC_IDLE;
         vlan_cmd_reg   <= CMD_RESET;
         vlan_wval_reg  <= ENTRY_RESET;
         vlan_rval_reg  <= ENTRY_RESET;
      end else begin
         vlan_state_reg <= vlan_state_next;
         vlan_cmd_reg   <= vlan_cmd_next;
         vlan_wval_reg  <= vlan_wval_next;
         vlan_rval_reg  <= vlan_rval_next;
      end
   end

   // VLAN entries and ingress match
   vlan_entry_store u_vlan_store (
      .clk_i         (clk_i),
      .rst_n_i       (rst_n_i),
      .wr_en_i       (vlan_mem_we),
      .rd_en_i       (vlan_mem_re),
      .index_i       (vlan_cmd_reg[VLAN_INDEX_W-1:0]),
      .wdata_i       (vlan_wval_reg),
      .rdata_o       (vlan_mem_rdata),
      .ingress_vid_i (ingress_vid_i),
      .hybrid_i      (egress_port_type_config_i),
      .admit_o       (vlan_admit_o),
      .strip_tag_o   (vlan_strip_tag_o),
      .hit_o         (vlan_hit_o)
   );

endmodule

/* tb/vlan_dscp_table_access_sva.sv */
// Concurrent checks on the bus and VLAN lookup ports of the table access bank
`timescale 1ns/1ps
module vlan_dscp_table_access_sva
   import vlan_dscp_pkg::*;
(
   input wire logic                    clk_i,
   input wire logic                    rst_n_i,
   input wire logic                    hsel_i,
   input wire logic [ADDR_W-1:0]       haddr_i,
   input wire logic [1:0]              htrans_i,
   input wire logic                    hwrite_i,
   input wire logic [2:0]              hsize_i,
   input wire logic [DATA_W-1:0]       hwdata_i,
   input wire logic                    hready_i,
   input wire logic [DATA_W-1:0]       hrdata_o,
   input wire logic                    hreadyout_o,
   input wire logic                    hresp_o,
   input wire logic [VID_W-1:0]        ingress_vid_i,
   input wire logic [NUM_PORTS-1:0]    egress_port_type_config_i,
   input wire logic [NUM_PORTS-1:0]    vlan_admit_o,
   input wire logic [NUM_PORTS-1:0]    vlan_strip_tag_o,
   input wire logic                    vlan_hit_o,
   input wire logic [DSCP_INDEX_W-1:0] tos_class_i,
   input wire logic [DSCP_PRIO_W-1:0]  rx_priority_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   // Address phase taken by the slave
   wire logic acc = hsel_i && hready_i && htrans_i[1] && hsize_i == HSIZE_WORD && haddr_i[1:0] == BYTE_ALIGNED;

   // Read answer shape: one wait cycle, then ready
   sequence s_rd_acc;
      acc && !hwrite_i;
   endsequence
   sequence s_wait_one;
      !hreadyout_o ##1 hreadyout_o;
   endsequence

   property p_read_wait; s_rd_acc |=> s_wait_one; endproperty
   property p_write_nowait; acc && hwrite_i |=> hreadyout_o; endproperty
   property p_one_wait; !hreadyout_o |=> hreadyout_o; endproperty
   property p_hresp_okay; !hresp_o; endproperty
   property p_rdata_hold; hreadyout_o && $past(hreadyout_o) |-> $stable(hrdata_o); endproperty
   property p_null_vid; ingress_vid_i == NULL_VID |=> !vlan_hit_o && vlan_admit_o == 2'b00; endproperty
   property p_admit_hit; vlan_admit_o != 2'b00 || vlan_strip_tag_o != 2'b00 |-> vlan_hit_o; endproperty
   property p_strip_hybrid;
      1'b1 |=> (vlan_strip_tag_o & ~$past(egress_port_type_config_i)) == 2'b00;
   endproperty

   a_read_wait: assert property (p_read_wait) else $error("read answer not one wait cycle");
   a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
   a_one_wait: assert property (p_one_wait) else $error("ready low for two cycles");
   a_hresp_okay: assert property (p_hresp_okay) else $error("error response seen");
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved while idle");
   a_null_vid: assert property (p_null_vid) else $error("null vid matched");
   a_admit_hit: assert property (p_admit_hit) else $error("admit or strip without hit");
   a_strip_hybrid: assert property (p_strip_hybrid) else $error("strip on non hybrid port");
endmodule

bind vlan_dscp_table_access vlan_dscp_table_access_sva u_sva (.*);

/* tb/vlan_dscp_table_access_tb.sv */
// Self-checking bench for the table access register bank
`timescale 1ns/1ps
module vlan_dscp_table_access_tb;
   import vlan_dscp_pkg::*;
   logic                    clk_i, rst_n_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, vlan_hit_o;
   logic [ADDR_W-1:0]       haddr_i;
   logic [1:0]              htrans_i;
   logic [2:0]              hsize_i;
   logic [DATA_W-1:0]       hwdata_i, hrdata_o, rd;
   logic [VID_W-1:0]        ingress_vid_i;
   logic [NUM_PORTS-1:0]    egress_port_type_config_i, vlan_admit_o, vlan_strip_tag_o;
   logic [DSCP_INDEX_W-1:0] tos_class_i;
   logic [DSCP_PRIO_W-1:0]  rx_priority_o;
   int                      n_fail, tests_run;

   vlan_dscp_table_access DUT (.*, .hready_i(hreadyout_o));

   // Clock generator
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Wait for hready sampled high at a rising edge
   task automatic wait_ready();
      int n;
      n = 0;
      @(posedge clk_i);
      while (hreadyout_o !== 1'b1 && n < 100) begin
         @(posedge clk_i);
         n++;
      end
   endtask

   // One single-word transfer; read data lands in rd
   task automatic bus(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd);
      hsel_i <= 1'b1;
      htrans_i <= 2'h2;
      haddr_i <= {idx, BYTE_ALIGNED};
      hwrite_i <= wr;
      hsize_i <= HSIZE_WORD;
      wait_ready();
      hsel_i <= 1'b0;
      htrans_i <= HTRANS_IDLE;
      hwdata_i <= wd;
      wait_ready();
      rd = hrdata_o;
   endtask

   function automatic logic [2:0] prio(input int i);
      return 3'(i) ^ 3'(i >> 3);
   endfunction

   // Issue a table command, then poll its pending flag until clear
   task automatic table_cmd(input logic [IDX_W-1:0] cmd, input logic [IDX_W-1:0] pend, input logic [31:0] w);
      int n;
      n = 0;
      bus(1'b1, cmd, w);
      bus(1'b0, pend, '0);
      check("pending after command", rd, 32'h1);
      while (rd !== 32'h0 && n < 50) begin
         bus(1'b0, pend, '0);
         n++;
      end
      check("pending cleared", rd, 32'h0);
   endtask

   task automatic look(input logic [11:0] vid, input logic [1:0] hyb, input logic [1:0] adm, input logic [1:0] strip,
                       input logic hit);
      ingress_vid_i <= vid;
      egress_port_type_config_i <= hyb;
      repeat (2) @(posedge clk_i);
      check("vlan_admit_o", {30'h0, vlan_admit_o}, {30'h0, adm});
      check("vlan_strip_tag_o", {30'h0, vlan_strip_tag_o}, {30'h0, strip});
      check("vlan_hit_o", {31'h0, vlan_hit_o}, {31'h0, hit});
   endtask

   // Reset values, read-only and unmapped places
   task automatic t_reset_values();
      logic [IDX_W-1:0] regs [6] = '{VLAN_COMMAND_PENDING_IDX, DSCP_TABLE_COMMAND_IDX, DSCP_TABLE_WRITE_VALUE_IDX,
                                     DSCP_TABLE_READ_VALUE_IDX, DSCP_TABLE_PENDING_IDX, 14'h0100};
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, regs[i], '0);
         check("reset value", rd, WORD_RESET);
      end
      foreach (regs[i]) if (i == 0 || i > 2) bus(1'b1, regs[i], 32'hFFFF_FFFF);
      foreach (regs[i]) begin
         bus(1'b0, regs[i], '0);
         check("read-only or unmapped after write", rd, WORD_RESET);
      end
      $display("t_reset_values finished");
   endtask

   // Fill the whole priority table, read every entry back and look it up
   task automatic t_dscp_table();
      for (int i = 0; i < DSCP_DEPTH; i++) begin
         bus(1'b1, DSCP_TABLE_WRITE_VALUE_IDX, 32'hFFFF_FFF8 | prio(i));
         table_cmd(DSCP_TABLE_COMMAND_IDX, DSCP_TABLE_PENDING_IDX, {24'h0, 2'b01, i[5:0]});
      end
      bus(1'b0, DSCP_TABLE_WRITE_VALUE_IDX, '0);
      check("write value reserved bits", rd, {29'h0, prio(DSCP_DEPTH - 1)});
      bus(1'b0, DSCP_TABLE_COMMAND_IDX, '0);
      check("command reserved bit", rd, 32'h0000_003F);
      for (int i = 0; i < DSCP_DEPTH; i++) begin
         table_cmd(DSCP_TABLE_COMMAND_IDX, DSCP_TABLE_PENDING_IDX, {24'hFF_FFFF, 2'b10, i[5:0]});
         bus(1'b0, DSCP_TABLE_READ_VALUE_IDX, '0);
         check("dscp_table_read_value", rd, {29'h0, prio(i)});
         tos_class_i <= i[5:0];
         repeat (2) @(posedge clk_i);
         check("rx_priority_o", {29'h0, rx_priority_o}, {29'h0, prio(i)});
      end
      $display("t_dscp_table finished");
   endtask

   // Second command while the first is pending is dropped
   task automatic t_dscp_busy();
      bus(1'b1, DSCP_TABLE_COMMAND_IDX, 32'h0000_0089);
      bus(1'b1, DSCP_TABLE_COMMAND_IDX, 32'h0000_0094);
      bus(1'b0, DSCP_TABLE_PENDING_IDX, '0);
      check("pending after dropped command", rd, 32'h0);
      bus(1'b0, DSCP_TABLE_READ_VALUE_IDX, '0);
      check("read value after dropped command", rd, {29'h0, prio(9)});
      bus(1'b0, DSCP_TABLE_COMMAND_IDX, '0);
      check("command after dropped command", rd, 32'h0000_0089);
      $display("t_dscp_busy finished");
   endtask

   // VLAN entries: field positions, membership, untagging, null VID
   task automatic t_vlan();
      logic [15:0] ent [3] = '{16'hC123, 16'h2000, 16'h3456};
      logic [3:0]  pos [3] = '{4'h3, 4'h5, 4'h7};
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, VLAN_TABLE_WRITE_VALUE_IDX, {16'h0, ent[i]});
         table_cmd(VLAN_TABLE_COMMAND_IDX, VLAN_COMMAND_PENDING_IDX, {28'h0, pos[i]});
      end
      look(12'h123, 2'b11, 2'b10, 2'b10, 1'b1);
      look(12'h123, 2'b01, 2'b10, 2'b00, 1'b1);
      look(12'h456, 2'b01, 2'b01, 2'b01, 1'b1);
      look(12'h456, 2'b10, 2'b01, 2'b00, 1'b1);
      look(12'h000, 2'b11, 2'b00, 2'b00, 1'b0);
      look(12'h777, 2'b11, 2'b00, 2'b00, 1'b0);
      table_cmd(VLAN_TABLE_COMMAND_IDX, VLAN_COMMAND_PENDING_IDX, 32'h0000_0083);
      bus(1'b0, VLAN_TABLE_READ_VALUE_IDX, '0);
      check("vlan entry read back", rd, 32'h0000_C123);
      $display("t_vlan finished");
   endtask

   // A reset in mid-run keeps the priority table
   task automatic t_second_reset();
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      bus(1'b0, DSCP_TABLE_COMMAND_IDX, '0);
      check("command after reset", rd, WORD_RESET);
      table_cmd(DSCP_TABLE_COMMAND_IDX, DSCP_TABLE_PENDING_IDX, 32'h0000_0095);
      bus(1'b0, DSCP_TABLE_READ_VALUE_IDX, '0);
      check("dscp entry kept over reset", rd, {29'h0, prio(21)});
      look(12'h123, 2'b11, 2'b00, 2'b00, 1'b0);
      $display("t_second_reset finished");
   endtask

   // Watchdog against a hung handshake
   initial begin
      repeat (30000) @(posedge clk_i);
      n_fail++;
      test_done();
   end

   // Main sequence
   initial begin
      n_fail = 0;
      tests_run = 0;
      rst_n_i = 1'b0;
      hsel_i = 1'b0;
      haddr_i = '0;
      htrans_i = HTRANS_IDLE;
      hwrite_i = 1'b0;
      hsize_i = HSIZE_WORD;
      hwdata_i = '0;
      ingress_vid_i = '0;
      egress_port_type_config_i = '0;
      tos_class_i = '0;
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      t_reset_values();
      t_dscp_table();
      t_dscp_busy();
      t_vlan();
      t_second_reset();
      test_done();
   end
endmodule
